// ### eepac_pkg.sv
// Package: constants and types for the EEPROM page access control block
package eepac_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the core's special function bus
  // ----------------------------------------------------------------------
  localparam logic [2:0] EEPAC_ADDR_OFS   = 3'h1;
  localparam logic [2:0] EEPAC_DATA_OFS   = 3'h3;
  localparam logic [2:0] EEPAC_CTRL_OFS   = 3'h4;
  localparam logic [2:0] EEPAC_RELOAD_OFS = 3'h5;

  // ----------------------------------------------------------------------
  // Control word bit positions
  // ----------------------------------------------------------------------
  localparam int EEPAC_BIT_IEN  = 6;
  localparam int EEPAC_BIT_UFL  = 5;
  localparam int EEPAC_BIT_CIP  = 4;
  localparam int EEPAC_BIT_MS3  = 3;
  localparam int EEPAC_BIT_MS2  = 2;
  localparam int EEPAC_BIT_MS1  = 1;

  // ----------------------------------------------------------------------
  // Reset values, erased byte, timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] EEPAC_RST_BYTE    = 8'h00;
  localparam logic [7:0] EEPAC_ERASED_BYTE = 8'h00;
  localparam logic [1:0] EEPAC_LAST_LATCH  = 2'h3;
  localparam int         EEPAC_CLK_MHZ     = 100;
  localparam int         EEPAC_TICK_NS     = 4800;
  localparam int         EEPAC_TICK_CYC    = EEPAC_TICK_NS * EEPAC_CLK_MHZ / 1000;
  localparam int         EEPAC_INTERVAL_MS = 5;
  localparam int         EEPAC_PAGES       = 32;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    EEPAC_IDLE   = 2'b00,
    EEPAC_ERASE  = 2'b01,
    EEPAC_WRITE  = 2'b10,
    EEPAC_ERWR   = 2'b11
  } eepac_cyc_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] ofs;
    logic [7:0] wdata;
  } eepac_req_t;

endpackage

// ### eepac_top.sv
// Module: EEPROM page access control with latches, flags, timer and array
// Behaviour
// - Latches are write-only; data port writes OR into the latch.
// - Latches clear when any timed cycle ends without a data port write in its final clock.
// - Writing a latch sets its hidden byte-select flag.
// - Byte-select flags clear when any timed cycle ends, except the flag of a latch written by the data port in its final clock.
// - Read-byte mode data read returns addressed byte at once.
// - Write and erase last one timer interval; erase-write two.
// - Page cycles use the page index, ignoring latch index bits.
// - Bytes with clear flags stay unchanged during page cycles.
// - Erase page erases exactly the flagged bytes.
// - Write page ORs latch data into flagged bytes only.
// - Erase-write erases flagged bytes then writes latch data.
// - Increment mode advances latch index per write, stopping at 3.
// - Page setup uses only latch index to pick the latch.
// - Each read-byte mode data read increments the whole address, across pages.
// - Write or erase-write end increments address; latch 3 wraps page.
// - Control write with cycle bit set and a write, erase or erase-write mode starts cycle and timer.
// - Erase-write reloads timer after first interval for writing.
// - Cycle end clears cycle bit and may raise timer interrupt.
// - Control holds cycle bit 4, mode bits 3..1, bit 0 zero.
// - Address holds page index 6..2, latch index 1..0, bit 7 zero.
// - Data write loads latch by low bits; read returns array byte.
// - Final underflow stops timer, sets flag, clears cycle and mode.
`timescale 1ns/1ns
module eepac_top
  import eepac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire eepac_req_t req_i,
  input  wire logic       irq_global_en_i,
  output logic [7:0]      rdata_o,
  output logic            cycle_busy_o,
  output logic            timer_irq_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Latch byte i pairs with byte-select flag i
  typedef struct packed {
    logic [7:0]  addr;
    logic        ien;
    logic        ufl;
    logic        cip;
    logic [2:0]  ms;
    logic [7:0]  reload;
    logic [7:0]  count;
    logic [8:0]  presc;
    logic        run;
    eepac_cyc_t  cyc;
    logic        second;
    logic [31:0] latch;
    logic [3:0]  flags;
    logic [7:0]  rdata;
    logic        irq;
  } eepac_state_t;

  eepac_state_t st_reg;
  eepac_state_t st_next;
  logic [7:0]   mem_reg [0:255];
  logic [7:0]   ctrl_word;
  logic         page_we;
  logic [4:0]   page_sel;
  logic [31:0]  page_data;

  function automatic logic [7:0] eepac_ctrl(input eepac_state_t s);
    eepac_ctrl = {1'b0, s.ien, s.ufl, s.cip, s.ms, 1'b0};
  endfunction

  assign ctrl_word = eepac_ctrl(st_reg);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Array index of byte i of a page
  function automatic logic [7:0] eepac_byte_addr(input logic [4:0] page, input int i);
    eepac_byte_addr = {1'b0, page, 2'(i)};
  endfunction

  // Seven-bit wrap: address bit 7 can never become set
  function automatic logic [7:0] eepac_addr_inc(input logic [7:0] a);
    eepac_addr_inc = {1'b0, 7'(a[6:0] + 7'h01)};
  endfunction

  // Auto-increments only act while no cycle bit is set
  function automatic logic eepac_read_mode(input eepac_state_t s);
    eepac_read_mode = !s.cip && s.ms == 3'b000;
  endfunction

  function automatic logic eepac_inc_mode(input eepac_state_t s);
    eepac_inc_mode = !s.cip && s.ms == 3'b010;
  endfunction

  // Illegal mode words map to idle, so they start nothing
  function automatic eepac_cyc_t eepac_decode(input logic [2:0] ms);
    case (ms)
      3'b010, 3'b011: eepac_decode = EEPAC_WRITE;
      3'b100:         eepac_decode = EEPAC_ERWR;
      3'b111:         eepac_decode = EEPAC_ERASE;
      default:        eepac_decode = EEPAC_IDLE;
    endcase
  endfunction

  // Latch loads can only set bits, never clear them
  function automatic logic [31:0] eepac_latch_or(
    input logic [31:0] latch,
    input logic [1:0]  idx,
    input logic [7:0]  d
  );
    logic [31:0] res;
    res = latch;
    for (int i = 0; i < 4; i++) begin
      if (2'(i) == idx) begin
        res[i*8 +: 8] = latch[i*8 +: 8] | d;
      end
    end
    eepac_latch_or = res;
  endfunction

  // New page image; an unflagged byte always keeps its old value
  function automatic logic [31:0] eepac_merge(
    input logic [31:0] old,
    input logic [31:0] latch,
    input logic [3:0]  flags,
    input logic        erase_only
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (flags[i] && erase_only) begin
        res[i*8 +: 8] = EEPAC_ERASED_BYTE;
      end else if (flags[i]) begin
        res[i*8 +: 8] = old[i*8 +: 8] | latch[i*8 +: 8];
      end
    end
    eepac_merge = res;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        done;
    logic [31:0] old;
    logic [1:0]  li;
    st_next   = st_reg;
    page_we   = 1'b0;
    page_sel  = st_reg.addr[6:2];
    page_data = '0;
    tick      = 1'b0;
    done      = 1'b0;
    old       = '0;
    li        = st_reg.addr[1:0];

    // ----------------------------------------------------------------------
    // Page image
    // ----------------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = mem_reg[eepac_byte_addr(st_reg.addr[6:2], i)];
    end

    // ----------------------------------------------------------------------
    // Timer and page cycles
    // ----------------------------------------------------------------------
    // Prescaler gives one decrement per 480 oscillator periods equivalent
    if (st_reg.run) begin
      if (st_reg.presc == 9'(EEPAC_TICK_CYC - 1)) begin
        st_next.presc = '0;
        tick          = 1'b1;
      end else begin
        st_next.presc = st_reg.presc + 9'h001;
      end
    end

    if (tick) begin
      if (st_reg.count != 8'h00) begin
        st_next.count = st_reg.count - 8'h01;
      end else if (st_reg.cyc == EEPAC_ERWR && !st_reg.second) begin
        // First interval over: erase flagged bytes, reload for writing
        page_data = eepac_merge(old, st_reg.latch, st_reg.flags, 1'b1);
        page_we        = 1'b1;
        st_next.second = 1'b1;
        st_next.count  = st_reg.reload;
      end else begin
        // Second phase of erase-write ORs into bytes cleared a phase ago
        done      = 1'b1;
        page_data = eepac_merge(old, st_reg.latch, st_reg.flags, st_reg.cyc == EEPAC_ERASE);
        page_we = 1'b1;
      end
    end

    // ----------------------------------------------------------------------
    // Cycle end
    // ----------------------------------------------------------------------
    if (done) begin
      st_next.run    = 1'b0;
      st_next.ufl    = 1'b1;
      st_next.cip    = 1'b0;
      st_next.ms     = 3'b000;
      st_next.latch  = '0;
      st_next.flags  = '0;
      st_next.cyc    = EEPAC_IDLE;
      st_next.second = 1'b0;
      if (st_reg.cyc != EEPAC_ERASE) begin
        st_next.addr = eepac_addr_inc(st_reg.addr);
      end
    end

    // ----------------------------------------------------------------------
    // Core reads
    // ----------------------------------------------------------------------
    if (req_i.rd) begin
      case (req_i.ofs)
        EEPAC_ADDR_OFS:   st_next.rdata = {1'b0, st_reg.addr[6:0]};
        EEPAC_CTRL_OFS:   st_next.rdata = ctrl_word;
        EEPAC_RELOAD_OFS: st_next.rdata = st_reg.reload;
        EEPAC_DATA_OFS: begin
          st_next.rdata = mem_reg[{1'b0, st_reg.addr[6:0]}];
          if (eepac_read_mode(st_reg)) begin
            st_next.addr = eepac_addr_inc(st_reg.addr);
          end
        end
        default:          st_next.rdata = EEPAC_RST_BYTE;
      endcase
    end

    // ----------------------------------------------------------------------
    // Core writes
    // ----------------------------------------------------------------------
    if (req_i.wr) begin
      case (req_i.ofs)
        EEPAC_ADDR_OFS:   st_next.addr = {1'b0, req_i.wdata[6:0]};
        EEPAC_RELOAD_OFS: st_next.reload = req_i.wdata;
        EEPAC_DATA_OFS: begin
          st_next.latch     = eepac_latch_or(st_reg.latch, li, req_i.wdata);
          st_next.flags[li] = 1'b1;
          if (eepac_inc_mode(st_reg) && li != EEPAC_LAST_LATCH) begin
            st_next.addr[1:0] = li + 2'h1;
          end
        end
        EEPAC_CTRL_OFS: begin
          st_next.ien = req_i.wdata[EEPAC_BIT_IEN];
          st_next.ufl = req_i.wdata[EEPAC_BIT_UFL] | done;
          st_next.ms  = req_i.wdata[EEPAC_BIT_MS3:EEPAC_BIT_MS1];
          st_next.cip = req_i.wdata[EEPAC_BIT_CIP];
          if (req_i.wdata[EEPAC_BIT_CIP] && !st_reg.cip) begin
            // Start cycle and timer together; illegal codes do nothing
            st_next.cyc    = eepac_decode(req_i.wdata[EEPAC_BIT_MS3:EEPAC_BIT_MS1]);
            st_next.run    = (st_next.cyc != EEPAC_IDLE);
            st_next.cip    = (st_next.cyc != EEPAC_IDLE);
            st_next.count  = st_reg.reload;
            st_next.presc  = '0;
            st_next.second = 1'b0;
          end else if (st_reg.cip) begin
            // A write during a cycle cannot drop its cycle bit
            st_next.cip = st_reg.cip & ~done;
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------------
    st_next.irq = st_next.ufl & st_next.ien & irq_global_en_i;
  end

  // ----------------------------------------------------------------------
  // Registers and nonvolatile array
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Array is not reset: it models retained nonvolatile content
  always_ff @(posedge clk_i) begin
    if (page_we) begin
      for (int i = 0; i < 4; i++) begin
        mem_reg[eepac_byte_addr(page_sel, i)] <= page_data[i*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdata_o      = st_reg.rdata;
  assign cycle_busy_o = st_reg.cip;
  assign timer_irq_o  = st_reg.irq;

endmodule

// ### eepac_top_assertions.sv
// Checker: port-level properties of the EEPROM page access block
`timescale 1ns/1ns
module eepac_top_assertions
  import eepac_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire eepac_req_t req_i,
  input wire logic       irq_global_en_i,
  input wire logic [7:0] rdata_o,
  input wire logic       cycle_busy_o,
  input wire logic       timer_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0]  rel_reg;
  logic [19:0] len_reg;
  wire  [19:0] one_len = (20'(rel_reg) + 20'h00001) * 20'(EEPAC_TICK_CYC);
  // Shadow reload and busy length; two cycles of slack allowed at the ends
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rel_reg <= 8'h00;
      len_reg <= 20'h00000;
    end else begin
      if (req_i.wr && req_i.ofs == EEPAC_RELOAD_OFS) rel_reg <= req_i.wdata;
      len_reg <= cycle_busy_o ? len_reg + 20'h00001 : 20'h00000;
    end
  end
  start_cause_a: assert property ($rose(cycle_busy_o) |-> $past(req_i.wr && req_i.ofs == EEPAC_CTRL_OFS
    && req_i.wdata[EEPAC_BIT_CIP])) else $error("busy rose without a start word");
  min_busy_a: assert property ($rose(cycle_busy_o) |-> cycle_busy_o[*8]) else $error("cycle too short");
  cycle_len_a: assert property ($fell(cycle_busy_o) |-> (len_reg - one_len + 20'h00002 <= 20'h00004)
    || (len_reg - (one_len << 1) + 20'h00002 <= 20'h00004)) else $error("cycle length wrong");
  irq_gate_a: assert property (timer_irq_o |-> irq_global_en_i || $past(irq_global_en_i))
    else $error("irq without global enable");
  ctrl_bits_a: assert property (req_i.rd && req_i.ofs == EEPAC_CTRL_OFS |=> !rdata_o[0] && !rdata_o[7]
    && rdata_o[EEPAC_BIT_CIP] == $past(cycle_busy_o)) else $error("control read wrong");
  addr_bit7_a: assert property (req_i.rd && req_i.ofs == EEPAC_ADDR_OFS |=> !rdata_o[7])
    else $error("address bit 7 set");
  illegal_mode_a: assert property (req_i.wr && req_i.ofs == EEPAC_CTRL_OFS && !cycle_busy_o
    && req_i.wdata[3:1] inside {3'b001, 3'b101, 3'b110} |=> !cycle_busy_o) else $error("illegal mode ran");
  rdata_hold_a: assert property (!req_i.rd |=> $stable(rdata_o)) else $error("read data moved");
endmodule
bind eepac_top eepac_top_assertions u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
  .irq_global_en_i(irq_global_en_i), .rdata_o(rdata_o), .cycle_busy_o(cycle_busy_o), .timer_irq_o(timer_irq_o));

// ### eepac_core_model.sv
// Core model: issues register strobes toward the access block
`timescale 1ns/1ns
module eepac_core_model
  import eepac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output eepac_req_t      req_o
);
  initial req_o = '0;
  // Idle data is inverted so the block cannot lean on a stale value
  task automatic wr(input logic [2:0] ofs, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, ofs: ofs, wdata: d};
    @(negedge clk_i);
    req_o.wr = 1'b0;
    req_o.wdata = ~d;
  endtask
  task automatic rd(input logic [2:0] ofs, output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, ofs: ofs, wdata: ~req_o.wdata};
    @(negedge clk_i);
    req_o.rd = 1'b0;
    d = rdata_i;
  endtask
endmodule

// ### eepac_top_bench.sv
// Testbench: register sequences against the EEPROM page access block
`timescale 1ns/1ns
module eepac_top_bench import eepac_pkg::*;;
  logic       clk_i, nrst_i, irq_global_en_i, busy, irq;
  logic [7:0] rdata, v;
  eepac_req_t req;
  int         num_errors = 0;
  int         compares = 0;
  eepac_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .irq_global_en_i(irq_global_en_i),
    .rdata_o(rdata), .cycle_busy_o(busy), .timer_irq_o(irq));
  eepac_core_model core (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [2:0] ofs, input logic [7:0] exp);
    core.rd(ofs, v);
    check(v, exp);
  endtask
  task automatic fill(input logic [7:0] a, input logic [31:0] d, input int n);
    core.wr(EEPAC_ADDR_OFS, a);
    for (int i = 0; i < n; i++) core.wr(EEPAC_DATA_OFS, d[8*i +: 8]);
  endtask
  // Cycle length in whole intervals, rounded down after adding eight clocks of slack
  task automatic run(input logic [7:0] ctrl, input int k);
    int n;
    n = 0;
    core.wr(EEPAC_CTRL_OFS, ctrl);
    while (busy === 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(8'((n + 8) / EEPAC_TICK_CYC), 8'(k));
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    nrst_i = 1'b0;
    irq_global_en_i = 1'b0;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    core.wr(EEPAC_RELOAD_OFS, 8'h00);
    core.wr(EEPAC_CTRL_OFS, 8'h04);
    fill(8'h00, 32'h0, 4);
    run(8'h1e, 1);
    rdchk(EEPAC_ADDR_OFS, 8'h03);
    rdchk(EEPAC_CTRL_OFS, 8'h20);
    core.wr(EEPAC_CTRL_OFS, 8'h04);
    fill(8'h01, 32'h40, 1);
    fill(8'h00, 32'h800f3ca5, 4);
    run(8'h54, 1);
    rdchk(EEPAC_ADDR_OFS, 8'h04);
    check({7'h00, irq}, 8'h00);
    core.wr(EEPAC_CTRL_OFS, 8'h00);
    core.wr(EEPAC_ADDR_OFS, 8'h00);
    for (int i = 0; i < 4; i++) rdchk(EEPAC_DATA_OFS, 8'(32'h800f7ca5 >> (8 * i)));
    rdchk(EEPAC_ADDR_OFS, 8'h04);
    irq_global_en_i = 1'b1;
    core.wr(EEPAC_CTRL_OFS, 8'h04);
    fill(8'h7d, 32'h11, 1);
    core.wr(EEPAC_ADDR_OFS, 8'h00);
    run(8'h58, 2);
    rdchk(EEPAC_CTRL_OFS, 8'h60);
    check({7'h00, irq}, 8'h01);
    core.wr(EEPAC_CTRL_OFS, 8'h00);
    core.wr(EEPAC_ADDR_OFS, 8'h00);
    for (int i = 0; i < 4; i++) rdchk(EEPAC_DATA_OFS, 8'(32'h800f11a5 >> (8 * i)));
    check({7'h00, irq}, 8'h00);
    core.wr(EEPAC_CTRL_OFS, 8'h12);
    check({7'h00, busy}, 8'h00);
    rdchk(3'h2, 8'h00);
    end_sim();
  end
endmodule
